// ### dv/psw_mem_model.sv
// Program and data memory model that answers the window's fetches.
`timescale 1ns/1ps
`default_nettype none
module psw_mem_model
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Program memory side.
    input  wire logic        pm_req,
    input  wire logic [22:0] pm_addr,
    output logic      [23:0] pm_rdata,
    // Data memory side.
    input  wire logic        dm_req,
    input  wire logic [15:0] dm_addr,
    output logic      [15:0] dm_rdata
);
    // ==========================================================
    // Stored contents and answer span
    // ==========================================================
    logic        pm_hold_q; // Program word stays valid one cycle past the request.
    logic        dm_hold_q; // Data word stays valid one cycle past the request.
    logic [23:0] pm_word;   // Word held at pm_addr.
    logic [15:0] dm_word;   // Word held at dm_addr.
    // Upper byte is all ones or all zeros, so stray execution is harmless.
    assign pm_word = {{8{pm_addr[0]}}, pm_addr[15:0] ^ 16'hA5C3};
    assign dm_word = dm_addr ^ 16'h3C5A;
    // Remember each request for one cycle.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pm_hold_q <= 1'b0;
            dm_hold_q <= 1'b0;
        end
        else
        begin
            pm_hold_q <= pm_req;
            dm_hold_q <= dm_req;
        end
    end
    // Outside the span show the inverse, so a late capture cannot pass.
    assign pm_rdata = (pm_req | pm_hold_q) ? pm_word : ~pm_word;
    assign dm_rdata = (dm_req | dm_hold_q) ? dm_word : ~dm_word;
endmodule // psw_mem_model
`default_nettype wire

// ### dv/psw_window_properties.sv
// Concurrent checks on the window's CPU and memory ports.
`timescale 1ns/1ps
`default_nettype none
module psw_window_properties
#(
    parameter PAGE_W = 8,
    parameter OFF_W  = 15
)
(
    // Clock and reset.
    input wire logic                    clk,
    input wire logic                    arst_n,
    // CPU request and context.
    input wire logic                    cpu_req,
    input wire logic [15:0]             effective_address,
    input wire logic                    is_move,
    input wire logic                    in_repeat,
    input wire logic                    rep_first,
    input wire logic                    rep_last,
    input wire logic                    rep_irq_exit,
    input wire logic                    rep_irq_reentry,
    input wire logic                    table_op_active,
    // Answers and memory requests.
    input wire logic                    cpu_busy,
    input wire logic                    cpu_stall,
    input wire logic                    cpu_rsp_valid,
    input wire logic                    pm_req,
    input wire logic [PAGE_W+OFF_W-1:0] pm_addr,
    input wire logic                    dm_req
);
    // ==========================================================
    // One clock domain, one reset for every property.
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic edge_ctx; // Loop iteration that is charged the full penalty.
    assign edge_ctx = rep_first | rep_last | rep_irq_exit | rep_irq_reentry;
    // A taken request, then the cost classes once a fetch follows.
    sequence take_s; cpu_req && !cpu_busy; endsequence
    sequence move_s; take_s ##0 (!in_repeat && is_move) ##1 pm_req; endsequence
    sequence other_s; take_s ##0 (!in_repeat && !is_move) ##1 pm_req; endsequence
    sequence edge_s; take_s ##0 (in_repeat && edge_ctx) ##1 pm_req; endsequence
    sequence mid_s; take_s ##0 (in_repeat && !edge_ctx) ##1 pm_req; endsequence
    // ==========================================================
    // Routing
    // ==========================================================
    a_data_route: assert property (take_s ##0 !effective_address[15]
        |=> dm_req && !pm_req) else $error("low address reached program memory");
    a_table_hold: assert property (take_s ##0 table_op_active |=> !pm_req)
        else $error("fetch during table operation");
    a_fetch_cause: assert property (pm_req |-> $past(cpu_req)
        && $past(effective_address[15]) && !$past(table_op_active))
        else $error("fetch without window request");
    a_fetch_offset: assert property (pm_req
        |-> pm_addr[OFF_W-1:0] == $past(effective_address[14:0]))
        else $error("fetch offset differs from address");
    // ==========================================================
    // Cycle cost
    // ==========================================================
    a_move_cost: assert property (move_s |=> cpu_stall ##1
        (cpu_rsp_valid && !cpu_stall)) else $error("move cost not one cycle");
    a_other_cost: assert property (other_s |=> cpu_stall[*2] ##1
        (cpu_rsp_valid && !cpu_stall)) else $error("other cost not two cycles");
    a_rep_edge: assert property (edge_s |=> cpu_stall[*2] ##1
        (cpu_rsp_valid && !cpu_stall)) else $error("loop edge cost not two");
    a_rep_mid: assert property (mid_s |=> cpu_rsp_valid && !cpu_stall)
        else $error("loop middle iteration stalled");
    a_data_fast: assert property (take_s ##1 dm_req |=> cpu_rsp_valid
        && !cpu_stall) else $error("data memory access stalled");
endmodule // psw_window_properties
bind psw_window psw_window_properties #(.PAGE_W(PAGE_W), .OFF_W(OFF_W)) u_props (
    .clk(clk), .arst_n(arst_n), .cpu_req(cpu_req), .effective_address(effective_address),
    .is_move(is_move), .in_repeat(in_repeat), .rep_first(rep_first), .rep_last(rep_last),
    .rep_irq_exit(rep_irq_exit), .rep_irq_reentry(rep_irq_reentry),
    .table_op_active(table_op_active), .cpu_busy(cpu_busy), .cpu_stall(cpu_stall),
    .cpu_rsp_valid(cpu_rsp_valid), .pm_req(pm_req), .pm_addr(pm_addr), .dm_req(dm_req));
`default_nettype wire

// ### dv/test_psw_window.sv
// Self-checking bench for the program-space data window.
`timescale 1ns/1ps
`default_nettype none
`include "psw_regs.vh"
module test_psw_window;
    // ==========================================================
    // Signals
    // ==========================================================
    logic        clk, arst_n, reg_wr, reg_rd, cpu_req, pm_req, dm_req;
    logic        is_move, in_repeat, rep_first, rep_last, rep_irq_exit, rep_irq_reentry;
    logic        table_op_active, cpu_busy, cpu_stall, cpu_rsp_valid;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, effective_address, cpu_rsp_data, dm_addr, dm_rdata;
    logic [22:0] pm_addr;
    logic [23:0] pm_rdata;
    logic [7:0]  page;           // Page the bench last programmed.
    logic [25:0] cases [9];      // Address, context, fetch expected, extra cycles.
    int          num_errors, checks, cycles;
    psw_window DUT (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_req(cpu_req),
        .effective_address(effective_address), .is_move(is_move), .in_repeat(in_repeat),
        .rep_first(rep_first), .rep_last(rep_last), .rep_irq_exit(rep_irq_exit),
        .rep_irq_reentry(rep_irq_reentry), .table_op_active(table_op_active),
        .cpu_busy(cpu_busy), .cpu_stall(cpu_stall), .cpu_rsp_valid(cpu_rsp_valid),
        .cpu_rsp_data(cpu_rsp_data), .pm_req(pm_req), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_addr(dm_addr), .dm_rdata(dm_rdata));
    psw_mem_model u_mem (.clk(clk), .arst_n(arst_n), .pm_req(pm_req), .pm_addr(pm_addr),
        .pm_rdata(pm_rdata), .dm_req(dm_req), .dm_addr(dm_addr), .dm_rdata(dm_rdata));
    // ==========================================================
    // Tasks
    // ==========================================================
    // Compare four-state, so an unknown never passes.
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Verdict and end of run, reached from the sequence or the hang limit.
    task automatic end_of_test();
        if (num_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data appear in the cycle after the strobe and hold until the next read.
    task automatic rd(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata & m, e);
    endtask
    // One CPU read: route, address, cost in cycles, returned word, status.
    task automatic acc(input logic [15:0] ea, input logic [6:0] ctx, input logic pm,
                       input logic [1:0] n);
        logic [15:0] dexp;
        int w;
        int st;
        @(posedge clk);
        cpu_req <= 1'b1;
        effective_address <= ea;
        {table_op_active, is_move, in_repeat, rep_first, rep_last, rep_irq_exit,
         rep_irq_reentry} <= ctx;
        @(posedge clk);
        cpu_req <= 1'b0;
        #1;
        chk("pm_req", pm_req, pm);
        chk("dm_req", dm_req, !pm);
        chk("busy", cpu_busy, 1'b1);
        if (pm) chk("pm_addr", pm_addr, {page, ea[14:0]});
        else chk("dm_addr", dm_addr, ea);
        dexp = pm ? ({page[0], ea[14:0]} ^ 16'hA5C3) : (ea ^ 16'h3C5A);
        w = 0;
        st = 0;
        while (cpu_rsp_valid !== 1'b1 && w < 8)
        begin
            @(posedge clk);
            #1;
            st += (cpu_stall === 1'b1);
            w++;
        end
        chk("cycles", w, n + 1);
        chk("stall", st, n);
        chk("busy", cpu_busy, 1'b0);
        chk("rsp_data", cpu_rsp_data, dexp);
        rd(`PSW_OFF_STAT, 16'h0037, {10'h000, n, 1'b0, ea[15] & ctx[6], pm, 1'b0});
    endtask
    // ==========================================================
    // Clock, hang limit and main sequence
    // ==========================================================
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    initial
    begin
        {arst_n, reg_wr, reg_rd, cpu_req, reg_addr, reg_wdata, effective_address} = '0;
        {is_move, in_repeat, rep_first, rep_last, rep_irq_exit, rep_irq_reentry} = '0;
        table_op_active = 1'b0;
        {num_errors, checks, cycles} = '0;
        page = 8'h00;
        cases = '{{16'h8000, 7'h20, 3'h5}, {16'hFFFF, 7'h00, 3'h6}, {16'h7FFF, 7'h00, 3'h0},
                  {16'hC000, 7'h40, 3'h0}, {16'h9000, 7'h18, 3'h6}, {16'hA000, 7'h34, 3'h6},
                  {16'hB000, 7'h12, 3'h6}, {16'h8001, 7'h11, 3'h6}, {16'h8002, 7'h30, 3'h4}};
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        rd(`PSW_OFF_PAGE, 16'hFFFF, 16'h0000);
        rd(`PSW_OFF_CTRL, 16'hFFFF, 16'h0000);
        rd(4'hE, 16'hFFFF, 16'h0000);
        acc(16'h8123, 7'h20, 1'b0, 2'h0);
        wr(4'hE, 16'hFFFF);
        rd(4'hE, 16'hFFFF, 16'h0000);
        wr(`PSW_OFF_CTRL, 16'h0004);
        rd(`PSW_OFF_CTRL, 16'hFFFF, 16'h0004);
        for (int p = 0; p < 2; p++)
        begin
            page = p ? 8'h5A : 8'hFF;
            wr(`PSW_OFF_PAGE, {8'hAB, page});
            rd(`PSW_OFF_PAGE, 16'hFFFF, {8'h00, page});
            foreach (cases[i]) acc(cases[i][25:10], cases[i][9:3], cases[i][2], cases[i][1:0]);
        end
        wr(`PSW_OFF_CTRL, 16'h0000);
        acc(16'h8000, 7'h00, 1'b0, 2'h0);
        // Mid-run reset is applied on a clock edge like every other input.
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(`PSW_OFF_PAGE, 16'hFFFF, 16'h0000);
        end_of_test();
    end
endmodule // test_psw_window
`default_nettype wire

// ### logic/psw_cost.v
// Extra-cycle cost of one window access from instruction class and loop context.
`timescale 1ns/1ps
`default_nettype none
`include "psw_regs.vh"

module psw_cost
(
    // Instruction class and loop context.
    input  wire       is_move,
    input  wire       in_repeat,
    input  wire       rep_first,
    input  wire       rep_last,
    input  wire       rep_irq_exit,
    input  wire       rep_irq_reentry,
    // Extra cycles for this access.
    output reg  [1:0] extra
);

    // Loop edges pay the full cost; the steady middle of a loop pays none.
    always @*
    begin
        extra = `PSW_EXTRA_NONE;
        if (!in_repeat)
        begin
            // Word and double-word moves hide one of the two fetches.
            if (is_move)
                extra = `PSW_EXTRA_MOVE;
            else
                extra = `PSW_EXTRA_OTHER;
        end
        else if (rep_first || rep_last || rep_irq_exit || rep_irq_reentry)
        begin
            extra = `PSW_EXTRA_REP_EDGE;
        end
        else
        begin
            // Prefetch overlaps the repeated fetches, so no stall here.
            extra = `PSW_EXTRA_NONE;
        end
    end

endmodule // psw_cost
`default_nettype wire

// ### logic/psw_regs.vh
// Constants for the program-space data window: register map, fields, cycle costs.
`ifndef PSW_REGS_VH
`define PSW_REGS_VH

// ==========================================================================
// Register offsets on the plain register port.
// ==========================================================================
`define PSW_OFF_PAGE       4'h0
`define PSW_OFF_CTRL       4'h2
`define PSW_OFF_STAT       4'h4

// ==========================================================================
// Field positions and reset values.
// ==========================================================================
`define PSW_CTRL_WIN_EN    2
`define PSW_PAGE_RST       8'h00
`define PSW_CTRL_RST       16'h0000
`define PSW_EA_MSB         15
`define PSW_STAT_BUSY      0
`define PSW_STAT_LASTWIN   1
`define PSW_STAT_SUSP      2
`define PSW_STAT_EXTRA_LO  4

// ==========================================================================
// Extra instruction cycles charged for a window access.
// ==========================================================================
`define PSW_EXTRA_NONE     2'h0
`define PSW_EXTRA_MOVE     2'h1
`define PSW_EXTRA_OTHER    2'h2
`define PSW_EXTRA_REP_EDGE 2'h2
`define PSW_CNT_ONE        2'h1

`endif

// ### logic/psw_window.v
// Top of the program-space data window bridge between CPU data reads and memories.
`timescale 1ns/1ps
`default_nettype none
`include "psw_regs.vh"

module psw_window
#(
    parameter PAGE_W = 8,
    parameter OFF_W  = 15,
    parameter DATA_W = 16,
    parameter PWORD_W = 24
)
(
    // Clock and reset.
    input  wire                    clk,
    input  wire                    arst_n,
    // Register port.
    input  wire [3:0]              reg_addr,
    input  wire [15:0]             reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [15:0]             reg_rdata,
    // CPU data read request.
    input  wire                    cpu_req,
    input  wire [15:0]             effective_address,
    input  wire                    is_move,
    input  wire                    in_repeat,
    input  wire                    rep_first,
    input  wire                    rep_last,
    input  wire                    rep_irq_exit,
    input  wire                    rep_irq_reentry,
    input  wire                    table_op_active,
    // CPU answer.
    output reg                     cpu_busy,
    output reg                     cpu_stall,
    output reg                     cpu_rsp_valid,
    output reg  [DATA_W-1:0]       cpu_rsp_data,
    // Program memory side, data taken at the clock edge that ends the request cycle.
    output reg                     pm_req,
    output reg  [PAGE_W+OFF_W-1:0] pm_addr,
    input  wire [PWORD_W-1:0]      pm_rdata,
    // Data memory side, data taken at the clock edge that ends the request cycle.
    output reg                     dm_req,
    output reg  [15:0]             dm_addr,
    input  wire [DATA_W-1:0]       dm_rdata
);

    // ======================================================================
    // State encoding, one-hot.
    // ======================================================================
    localparam [3:0] ST_IDLE = 4'h1;   // Ready for a request.
    localparam [3:0] ST_PM   = 4'h2;   // Program fetch in flight.
    localparam [3:0] ST_DM   = 4'h4;   // Data fetch in flight.
    localparam [3:0] ST_WAIT = 4'h8;   // Charging extra cycles.

    // ======================================================================
    // Registers and internal signals.
    // ======================================================================
    reg  [PAGE_W-1:0] page_q;          // Window page select.
    reg  [15:0]       ctrl_q;          // Core control register.
    reg  [3:0]        state_q;         // Bridge state.
    reg  [1:0]        extra_q;         // Extra cycles owed by current access.
    reg  [1:0]        cnt_q;           // Remaining extra cycles.
    reg               last_win_q;      // Last access went to program memory.
    reg               last_susp_q;     // Last window hit was suspended.
    reg  [1:0]        last_extra_q;    // Cost of the last access.
    wire [1:0]        extra_w;         // Cost from the cost unit.
    wire              win_en;          // Window enable bit.
    wire              ea_high;         // Address lies in the upper half.
    wire              win_hit;         // Access is routed to program memory.
    wire              win_susp;        // Hit suppressed by a table operation.
    wire              take;            // Request accepted this cycle.

    // Decode the enable bit and the upper half of data space.
    assign win_en   = ctrl_q[`PSW_CTRL_WIN_EN];
    assign ea_high  = effective_address[`PSW_EA_MSB];
    assign win_hit  = ea_high && win_en && !table_op_active;
    assign win_susp = ea_high && win_en && table_op_active;
    assign take     = cpu_req && (state_q == ST_IDLE);

    // Address match used by both the write and the read decoder.
    function is_off;
        input [3:0] a;
        input [3:0] off;
        begin
            is_off = (a == off);
        end
    endfunction

    // ======================================================================
    // Cost unit.
    // ======================================================================
    psw_cost u_cost
    (
        .is_move         (is_move),
        .in_repeat       (in_repeat),
        .rep_first       (rep_first),
        .rep_last        (rep_last),
        .rep_irq_exit    (rep_irq_exit),
        .rep_irq_reentry (rep_irq_reentry),
        .extra           (extra_w)
    );

    // ======================================================================
    // Register writes.
    // ======================================================================
    // Software owns page and control; the bridge never writes them itself.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            page_q <= `PSW_PAGE_RST;
            ctrl_q <= `PSW_CTRL_RST;
        end
        else if (reg_wr)
        begin
            // All 256 pages are reachable through the full byte.
            if (is_off(reg_addr, `PSW_OFF_PAGE))
                page_q <= reg_wdata[PAGE_W-1:0];
            if (is_off(reg_addr, `PSW_OFF_CTRL))
                ctrl_q <= reg_wdata;
        end
    end

    // ======================================================================
    // Register reads, answered one cycle after the strobe.
    // ======================================================================
    // Unmapped offsets read as zero; the status word shows bridge state.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (reg_rd)
        begin
            reg_rdata <= 16'h0000;
            if (is_off(reg_addr, `PSW_OFF_PAGE))
                reg_rdata <= {{(16-PAGE_W){1'b0}}, page_q};
            else if (is_off(reg_addr, `PSW_OFF_CTRL))
                reg_rdata <= ctrl_q;
            else if (is_off(reg_addr, `PSW_OFF_STAT))
            begin
                reg_rdata[`PSW_STAT_BUSY]    <= (state_q != ST_IDLE);
                reg_rdata[`PSW_STAT_LASTWIN] <= last_win_q;
                reg_rdata[`PSW_STAT_SUSP]    <= last_susp_q;
                reg_rdata[`PSW_STAT_EXTRA_LO+1:`PSW_STAT_EXTRA_LO] <= last_extra_q;
            end
        end
    end

    // ======================================================================
    // Access state machine.
    // ======================================================================
    // Requests arriving while busy are ignored; the core must watch cpu_busy.
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q       <= ST_IDLE;
            extra_q       <= `PSW_EXTRA_NONE;
            cnt_q         <= `PSW_EXTRA_NONE;
            cpu_busy      <= 1'b0;
            cpu_stall     <= 1'b0;
            cpu_rsp_valid <= 1'b0;
            cpu_rsp_data  <= {DATA_W{1'b0}};
            pm_req        <= 1'b0;
            pm_addr       <= {(PAGE_W+OFF_W){1'b0}};
            dm_req        <= 1'b0;
            dm_addr       <= 16'h0000;
            last_win_q    <= 1'b0;
            last_susp_q   <= 1'b0;
            last_extra_q  <= `PSW_EXTRA_NONE;
        end
        else
        begin
            // Strobes are one cycle long by default.
            pm_req        <= 1'b0;
            dm_req        <= 1'b0;
            cpu_rsp_valid <= 1'b0;
            case (state_q)
                ST_IDLE:
                begin
                    if (take && win_hit)
                    begin
                        // Page forms the top bits, EA low bits pass through.
                        pm_addr  <= {page_q, effective_address[OFF_W-1:0]};
                        pm_req   <= 1'b1;
                        extra_q  <= extra_w;
                        cpu_busy <= 1'b1;
                        last_win_q   <= 1'b1;
                        last_susp_q  <= 1'b0;
                        last_extra_q <= extra_w;
                        state_q  <= ST_PM;
                    end
                    else if (take)
                    begin
                        // Lower half, window off, or suspended: plain data read.
                        dm_addr  <= effective_address;
                        dm_req   <= 1'b1;
                        cpu_busy <= 1'b1;
                        last_win_q   <= 1'b0;
                        last_susp_q  <= win_susp;
                        last_extra_q <= `PSW_EXTRA_NONE;
                        state_q  <= ST_DM;
                    end
                end
                ST_PM:
                begin
                    // Upper byte of the program word is dropped here.
                    cpu_rsp_data <= pm_rdata[DATA_W-1:0];
                    if (extra_q == `PSW_EXTRA_NONE)
                    begin
                        cpu_rsp_valid <= 1'b1;
                        cpu_busy      <= 1'b0;
                        state_q       <= ST_IDLE;
                    end
                    else
                    begin
                        cpu_stall <= 1'b1;
                        cnt_q     <= extra_q;
                        state_q   <= ST_WAIT;
                    end
                end
                ST_DM:
                begin
                    // Ordinary data memory answers with no added cycles.
                    cpu_rsp_data  <= dm_rdata;
                    cpu_rsp_valid <= 1'b1;
                    cpu_busy      <= 1'b0;
                    state_q       <= ST_IDLE;
                end
                ST_WAIT:
                begin
                    // Stall stands for exactly the charged count of cycles.
                    if (cnt_q == `PSW_CNT_ONE)
                    begin
                        cpu_stall     <= 1'b0;
                        cpu_rsp_valid <= 1'b1;
                        cpu_busy      <= 1'b0;
                        state_q       <= ST_IDLE;
                    end
                    else
                    begin
                        cnt_q <= cnt_q - `PSW_CNT_ONE;
                    end
                end
                default:
                begin
                    // Recover from an illegal code without a reset.
                    cpu_stall <= 1'b0;
                    cpu_busy  <= 1'b0;
                    state_q   <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // psw_window
`default_nettype wire
